/* probe_pkg.sv */
package probe_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam longint CLK_HZ      = 100_000_000;
  localparam longint STARTUP_MS  = 2000;
  localparam longint PURGE_S     = 240;
  localparam longint TRIG_MS     = 50;
  // Longest time rounds down, least time rounds up
  localparam longint STARTUP_CYC = STARTUP_MS * CLK_HZ / 1000;
  localparam longint PURGE_CYC   = PURGE_S * CLK_HZ;
  localparam longint TRIG_CYC    = (TRIG_MS * CLK_HZ + 999) / 1000;
  localparam int     TMR_W       = 36;
  localparam int     TRIG_W      = 24;

  // ==========================================================
  // Scaling, in 0.01 % of scale and microamps
  // ==========================================================
  localparam int          SCALE_FULL = 10000;
  localparam logic [15:0] LIMIT_MAX  = 16'h07d0;
  localparam logic [31:0] CLIP_DEF   = 32'h0000_0000;
  localparam logic [31:0] ERR_DEF    = 32'h0000_00c8;
  localparam logic [31:0] ZCLIP_DEF  = 32'h8000_0000;
  localparam logic [15:0] ERR_UA_DEF = 16'h0e10;
  localparam int          UA_ZERO    = 4000;
  localparam int          UA_SPAN    = 16000;
  localparam int          DIS_BIT    = 31;

  // ==========================================================
  // Register map, byte addresses
  // ==========================================================
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LIM    = 8'h08;
  localparam logic [7:0] OFS_ERR_UA = 8'h18;
  localparam logic [7:0] OFS_ZCLIP  = 8'h1c;
  localparam int         CTRL_PURGE = 0;
  localparam int         CTRL_SEL   = 4;
  localparam int         SEL_W      = 2;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_SAMPLE = 5'b00001,
    ST_START  = 5'b00010,
    ST_SPURGE = 5'b00100,
    ST_RUN    = 5'b01000,
    ST_PURGE  = 5'b10000
  } seq_t;

endpackage

/* purge_trig.sv */
`timescale 1ns/1ns
`default_nettype none
module purge_trig #(
  parameter int              CNT_W    = probe_pkg::TRIG_W,
  parameter logic [CNT_W-1:0] TRIG_CYC = CNT_W'(probe_pkg::TRIG_CYC)
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Pin level and enable
  input  wire logic level_i,
  input  wire logic arm_i,
  // Request pulse
  output logic      trig_o
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             prev;
    logic             trig;
  } trig_st_t;

  trig_st_t q;
  trig_st_t d;

  // ==========================================================
  // Float-time measurement
  // ==========================================================
  // Count stays saturated so a long float still qualifies
  always_comb
  begin
    d = q;
    d.trig = 1'b0;
    d.prev = level_i;
    if (!arm_i)
      d.cnt = '0;
    else if (level_i)
    begin
      if (q.cnt != {CNT_W{1'b1}})
        d.cnt = q.cnt + 1'b1; // [R22]
    end
    else
    begin
      d.trig = q.prev && (q.cnt >= TRIG_CYC); // [R22]
      d.cnt = '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= d;
  end

  assign trig_o = q.trig;

  chk_short_release: assert property (@(posedge clk_i) disable iff (rst_i) // [R22]
    trig_o |-> ($past(q.cnt) >= TRIG_CYC && $past(q.prev) && !$past(level_i)))
    else $error("purge request from a too short release");

endmodule
`default_nettype wire

/* ch_map.sv */
`timescale 1ns/1ns
`default_nettype none
module ch_map (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Measurement and limits
  input  wire logic signed [15:0] meas_i,
  input  wire logic [3:0][31:0]   lim_i,
  input  wire logic [31:0]        zclip_i,
  input  wire logic [15:0]        err_ua_i,
  // Control
  input  wire logic               en_i,
  input  wire logic               force_i,
  input  wire logic               freeze_i,
  // Loop current in microamps
  output logic [15:0]             ua_o
);

  typedef struct packed {
    logic [15:0] ua;
  } ch_st_t;

  ch_st_t q;
  ch_st_t d;

  // ==========================================================
  // Clip, error and current mapping
  // ==========================================================
  // Limit order: lo clip, lo err, hi clip, hi err
  always_comb
  begin
    int m;
    int fs;
    logic err;
    m = int'(meas_i);
    fs = probe_pkg::SCALE_FULL;
    err = 1'b0;
    d = q;
    if (!zclip_i[probe_pkg::DIS_BIT] && m < int'(zclip_i[15:0]))
      m = 0; // [R8]
    err = (!lim_i[3][probe_pkg::DIS_BIT] && m > fs + int'(lim_i[3][15:0]))
       || (!lim_i[1][probe_pkg::DIS_BIT] && m < -int'(lim_i[1][15:0])); // [R14] [R17] [R18]
    if (!lim_i[2][probe_pkg::DIS_BIT] && m > fs + int'(lim_i[2][15:0]))
      m = fs + int'(lim_i[2][15:0]); // [R13] [R15]
    if (!lim_i[0][probe_pkg::DIS_BIT] && m < -int'(lim_i[0][15:0]))
      m = -int'(lim_i[0][15:0]); // [R13]
    // The loop cannot go past the 20 % extension at either end
    if (m > fs + int'(probe_pkg::LIMIT_MAX))
      m = fs + int'(probe_pkg::LIMIT_MAX);
    if (m < -int'(probe_pkg::LIMIT_MAX))
      m = -int'(probe_pkg::LIMIT_MAX);
    if (!en_i)
      d.ua = 16'h0000;
    else if (force_i)
      d.ua = err_ua_i; // [R6]
    else if (freeze_i)
      d.ua = q.ua; // [R12]
    else if (err)
      d.ua = err_ua_i; // [R14]
    else
      d.ua = 16'(probe_pkg::UA_ZERO + m * probe_pkg::UA_SPAN / fs); // [R11] [R16]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= d;
  end

  assign ua_o = q.ua;

  chk_force_err: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    (en_i && force_i) |=> (ua_o == $past(err_ua_i)))
    else $error("forced error level not shown");

  chk_freeze_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    (en_i && freeze_i && !force_i) |=> $stable(ua_o))
    else $error("frozen output moved");

endmodule
`default_nettype wire

/* probe_out_ctl.sv */
// How it works
// R1: Sample control pin once after reset release
// R2: Only one output mode drives pins
// R3: Host cycles power before changing mode
// R4: Outputs go active within start-up time
// R5: Start-up purge follows start-up directly
// R6: Analog outputs show error level then
// R7: Host ignores readings during warm-up
// R8: Readings below zero-clip limit read zero
// R9: Digital mode carries the Modbus RS-485 link
// R10: Two channels, each with selectable parameter
// R11: Range maps linearly onto 4 to 20 mA
// R12: Interval or manual purge freezes outputs
// R13: Past clipping limit output holds clipped
// R14: Past error limit output shows error
// R15: Separate low/high limits, 0 % and 2 %
// R16: Limits accepted from 0 to 20 %
// R17: Disabled limit causes no transition
// R18: Returning measurement reverses the transitions
// R19: Host releases pin at least 50 ms
// R20: Valid request starts a four-minute purge
// R21: Reset while floating selects digital mode
// R22: Short release pulses are ignored
//
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module probe_out_ctl #(
  parameter int                         NPARAM      = 4,
  parameter logic [probe_pkg::TMR_W-1:0] STARTUP_CYC =
    probe_pkg::TMR_W'(probe_pkg::STARTUP_CYC),
  parameter logic [probe_pkg::TMR_W-1:0] PURGE_CYC   =
    probe_pkg::TMR_W'(probe_pkg::PURGE_CYC),
  parameter logic [probe_pkg::TRIG_W-1:0] TRIG_CYC   =
    probe_pkg::TRIG_W'(probe_pkg::TRIG_CYC)
) (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic [31:0]                wb_dat_o,
  output logic                       wb_ack_o,
  // Output control pin, high while floating
  input  wire logic                  mode_pin_i,
  // Measurements, 0.01 % of scale each
  input  wire logic [NPARAM*16-1:0]  meas_i,
  // Modbus engine side
  input  wire logic                  mb_tx_i,
  input  wire logic                  mb_de_i,
  output logic                       mb_rx_o,
  // Shared pins: RS-485 line
  input  wire logic                  rs485_rx_i,
  output logic                       rs485_tx_o,
  output logic                       rs485_oe_n_o,
  // Shared pins: loop currents in microamps
  output logic [15:0]                loop0_ua_o,
  output logic [15:0]                loop1_ua_o,
  // Status
  output logic                       analog_o,
  output logic                       active_o,
  output logic                       purging_o
);

  localparam int SW = probe_pkg::SEL_W;

  typedef struct packed {
    probe_pkg::seq_t        st;
    logic                   analog;
    logic                   active;
    logic                   purging;
    logic                   freeze;
    logic [probe_pkg::TMR_W-1:0] tmr;
    logic                   ack;
    logic [31:0]            rdat;
    logic [3:0][31:0]       lim;
    logic [15:0]            err_ua;
    logic [31:0]            zclip;
    logic [2*SW-1:0]        sel;
    logic                   tx;
    logic                   oe_n;
    logic                   rx;
  } top_st_t;

  top_st_t     q;
  top_st_t     d;
  logic        trig;
  logic [15:0] ua [2];

  // ==========================================================
  // Helpers
  // ==========================================================
  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] merge(
    input logic [31:0] o,
    input logic [31:0] n,
    input logic [3:0]  s
  );
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
        r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction

  // A limit is kept only when disabled or within 0..20 %
  function automatic logic lim_ok(input logic [31:0] v);
    return v[probe_pkg::DIS_BIT] || (v[15:0] <= probe_pkg::LIMIT_MAX);
  endfunction

  // ==========================================================
  // Manual purge detection on the control pin
  // ==========================================================
  purge_trig #(
    .CNT_W    (probe_pkg::TRIG_W),
    .TRIG_CYC (TRIG_CYC)
  ) u_trig (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .level_i (mode_pin_i),
    .arm_i   (q.analog && q.st == probe_pkg::ST_RUN), // [R19] [R22]
    .trig_o  (trig)
  );

  // ==========================================================
  // Analog channels
  // ==========================================================
  // Each channel picks its parameter from the measurement bus
  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    logic signed [15:0] sel_meas;
    assign sel_meas = meas_i[int'(q.sel[c*SW +: SW]) * 16 +: 16]; // [R10]
    ch_map u_ch (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .meas_i   (sel_meas),
      .lim_i    (q.lim),
      .zclip_i  (q.zclip),
      .err_ua_i (q.err_ua),
      .en_i     (q.analog && q.active), // [R2] [R4]
      .force_i  (q.st == probe_pkg::ST_SPURGE), // [R6]
      .freeze_i (q.freeze), // [R12]
      .ua_o     (ua[c])
    );
  end

  assign loop0_ua_o = ua[0];
  assign loop1_ua_o = ua[1];

  // ==========================================================
  // Register bus and sequencer
  // ==========================================================
  // One-cycle answer; unmapped reads return zero
  always_comb
  begin
    logic        wr;
    logic        purge_req;
    logic [31:0] nv;
    int          li;
    wr = 1'b0;
    purge_req = 1'b0;
    nv = 32'h0;
    li = 0;
    d = q;
    d.ack = wb_cyc_i && wb_stb_i && !q.ack;
    d.rdat = 32'h0;
    wr = d.ack && wb_we_i;
    li = int'(wb_adr_i[4:2]) - 2;
    case ({wb_adr_i[7:2], 2'b00})
      probe_pkg::OFS_CTRL:
      begin
        d.rdat[probe_pkg::CTRL_SEL +: 2*SW] = q.sel;
        nv = merge({24'h0, q.sel, 4'h0}, wb_dat_i, wb_sel_i);
        if (wr)
        begin
          d.sel = nv[probe_pkg::CTRL_SEL +: 2*SW]; // [R10]
          purge_req = nv[probe_pkg::CTRL_PURGE];
        end
      end
      probe_pkg::OFS_STATUS:
        d.rdat = {24'h0, q.purging, q.active, q.st, q.analog};
      probe_pkg::OFS_LIM,
      probe_pkg::OFS_LIM + 8'h04,
      probe_pkg::OFS_LIM + 8'h08,
      probe_pkg::OFS_LIM + 8'h0c:
      begin
        d.rdat = q.lim[li];
        nv = merge(q.lim[li], wb_dat_i, wb_sel_i);
        // Out-of-range writes leave the old limit
        if (wr && lim_ok(nv))
          d.lim[li] = nv; // [R16] [R17]
      end
      probe_pkg::OFS_ERR_UA:
      begin
        d.rdat = {16'h0, q.err_ua};
        nv = merge({16'h0, q.err_ua}, wb_dat_i, wb_sel_i);
        if (wr)
          d.err_ua = nv[15:0];
      end
      probe_pkg::OFS_ZCLIP:
      begin
        d.rdat = q.zclip;
        if (wr)
          d.zclip = merge(q.zclip, wb_dat_i, wb_sel_i); // [R8]
      end
      default:
        d.rdat = 32'h0;
    endcase

    // Sequencer: timer counts within each timed state
    d.tmr = q.tmr + 1'b1;
    case (q.st)
      probe_pkg::ST_SAMPLE:
      begin
        // Floating pin reads high, so reset while floating gives digital
        d.analog = !mode_pin_i; // [R1] [R21]
        d.tmr = '0;
        d.st = probe_pkg::ST_START;
      end
      probe_pkg::ST_START:
        if (q.tmr >= STARTUP_CYC - 1'b1)
        begin
          d.tmr = '0;
          d.active = 1'b1; // [R4]
          d.purging = 1'b1; // [R5]
          d.st = probe_pkg::ST_SPURGE;
        end
      probe_pkg::ST_SPURGE:
        if (q.tmr >= PURGE_CYC - 1'b1)
        begin
          d.purging = 1'b0;
          d.st = probe_pkg::ST_RUN;
        end
      probe_pkg::ST_RUN:
      begin
        d.tmr = '0;
        if (purge_req || (trig && q.analog))
        begin
          d.purging = 1'b1; // [R20]
          d.freeze = 1'b1; // [R12]
          d.st = probe_pkg::ST_PURGE;
        end
      end
      probe_pkg::ST_PURGE:
        if (q.tmr >= PURGE_CYC - 1'b1)
        begin
          d.purging = 1'b0;
          d.freeze = 1'b0;
          d.st = probe_pkg::ST_RUN;
        end
      default:
      begin
        d.tmr = '0;
        d.st = probe_pkg::ST_SAMPLE;
      end
    endcase

    // Pin steering; the RS-485 driver stays off in analog mode
    d.tx = 1'b1;
    d.oe_n = 1'b1;
    d.rx = 1'b1;
    if (!q.analog && q.active)
    begin
      d.tx = mb_tx_i; // [R9]
      d.oe_n = !mb_de_i; // [R2]
      d.rx = rs485_rx_i;
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.st <= probe_pkg::ST_SAMPLE;
      q.lim <= {probe_pkg::ERR_DEF, probe_pkg::CLIP_DEF,
                probe_pkg::ERR_DEF, probe_pkg::CLIP_DEF}; // [R15]
      q.err_ua <= probe_pkg::ERR_UA_DEF;
      q.zclip <= probe_pkg::ZCLIP_DEF;
      q.tx <= 1'b1;
      q.oe_n <= 1'b1;
      q.rx <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // Registered outputs
  assign wb_dat_o     = q.rdat;
  assign wb_ack_o     = q.ack;
  assign mb_rx_o      = q.rx;
  assign rs485_tx_o   = q.tx;
  assign rs485_oe_n_o = q.oe_n;
  assign analog_o     = q.analog;
  assign active_o     = q.active;
  assign purging_o    = q.purging;

  // ==========================================================
  // Checks
  // ==========================================================
  chk_mode_fixed: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
    (q.st != probe_pkg::ST_SAMPLE && $past(q.st) != probe_pkg::ST_SAMPLE) |-> $stable(q.analog))
    else $error("output mode changed after sampling");

  chk_one_mode: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    q.analog |-> (rs485_oe_n_o && rs485_tx_o))
    else $error("RS-485 driver on in analog mode");

  chk_digital_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (!q.analog && $past(!q.analog)) |-> (loop0_ua_o == 16'h0000 && loop1_ua_o == 16'h0000))
    else $error("loop current in digital mode");

  chk_start_time: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    (q.st == probe_pkg::ST_START) |-> (q.tmr < STARTUP_CYC && !q.active))
    else $error("start-up overran its time");

  chk_startup_purge: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    ($past(q.st) == probe_pkg::ST_START && q.st != probe_pkg::ST_START)
      |-> (q.st == probe_pkg::ST_SPURGE && q.purging && q.active))
    else $error("start-up purge did not follow start-up");

  chk_limit_range: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
    $changed(q.lim) |-> (lim_ok(q.lim[0]) && lim_ok(q.lim[1]) && lim_ok(q.lim[2]) && lim_ok(q.lim[3])))
    else $error("limit outside 0 to 20 percent stored");

  chk_purge_len: assert property (@(posedge clk_i) disable iff (rst_i) // [R20]
    (q.st == probe_pkg::ST_PURGE) |-> (q.tmr < PURGE_CYC && q.purging && q.freeze))
    else $error("manual purge overran or not flagged");

endmodule
`default_nettype wire

/* probe_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module probe_host_model (
  // Clock
  input  wire logic clk_i,
  // Device line driver
  input  wire logic rs485_tx_i,
  input  wire logic rs485_oe_n_i,
  // Host transmit level
  input  wire logic host_tx_i,
  // Levels seen by the device
  output logic      mode_pin_o,
  output logic      line_o
);
  // ==========================================================
  // Relay on the control pin, high while released
  // ==========================================================
  // Starts floating, as an unwired pin would
  initial mode_pin_o = 1'b1;

  // Only called while the device is held in reset, so a mode change always meets a fresh sample
  task automatic set_mode(input logic floating);
    @(posedge clk_i);
    mode_pin_o <= floating;
  endtask

  // Release from ground for n cycles, then ground again
  task automatic release_pin(input int n);
    @(posedge clk_i);
    mode_pin_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    mode_pin_o <= 1'b0;
  endtask

  // ==========================================================
  // Shared line
  // ==========================================================
  // Device driver wins; otherwise the host drives, so the line never floats
  assign line_o = !rs485_oe_n_i ? rs485_tx_i : host_tx_i;
endmodule
`default_nettype wire

/* probe_output_mode_and_purge_control_test.sv */
`timescale 1ns/1ns
`default_nettype none
module probe_output_mode_and_purge_control_test;
  // ==========================================================
  // Stimulus and observed signals
  // ==========================================================
  logic        clk_i    = 1'b0;
  logic        rst_i    = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [63:0] meas_i   = 64'h0;
  logic        mb_tx_i  = 1'b1;
  logic        mb_de_i  = 1'b0;
  logic        host_tx  = 1'b1;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        mode_pin;
  logic        line;
  logic        mb_rx_o;
  logic        rs485_tx_o;
  logic        rs485_oe_n_o;
  logic [15:0] loop0_ua_o;
  logic [15:0] loop1_ua_o;
  logic        analog_o;
  logic        active_o;
  logic        purging_o;
  int          n_errors    = 0;
  int          comparisons = 0;
  int          cycles      = 0;

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  // Short counts keep the run small; expectations below assume these values
  probe_out_ctl #(.STARTUP_CYC(36'h14), .PURGE_CYC(36'h32), .TRIG_CYC(24'h5)) probe_out_ctl_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mode_pin_i(mode_pin), .meas_i(meas_i), .mb_tx_i(mb_tx_i), .mb_de_i(mb_de_i), .mb_rx_o(mb_rx_o),
    .rs485_rx_i(line), .rs485_tx_o(rs485_tx_o), .rs485_oe_n_o(rs485_oe_n_o), .loop0_ua_o(loop0_ua_o),
    .loop1_ua_o(loop1_ua_o), .analog_o(analog_o), .active_o(active_o), .purging_o(purging_o));

  probe_host_model probe_host_model_i (
    .clk_i(clk_i), .rs485_tx_i(rs485_tx_o), .rs485_oe_n_i(rs485_oe_n_o), .host_tx_i(host_tx),
    .mode_pin_o(mode_pin), .line_o(line));

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (n_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One classic cycle; holds everything until ack is sampled high
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (n == 50)
      n_errors++;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] junk;
    wb_xfer(1'b1, a, d, junk);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    wb_xfer(1'b0, a, 32'h0, v);
    check(name, v, exp);
  endtask

  // Loop outputs lag one cycle, so three edges leave them settled
  task automatic set_meas(input int v0, input int v1, input int v2, input int v3);
    @(posedge clk_i);
    meas_i <= {16'(v3), 16'(v2), 16'(v1), 16'(v0)};
    repeat (3) @(posedge clk_i);
  endtask

  task automatic loops(input int v, input int exp);
    set_meas(v, v, v, v);
    check("loop0", 32'(loop0_ua_o), 32'(exp));
    check("loop1", 32'(loop1_ua_o), 32'(exp));
  endtask

  task automatic wait_purging(input logic lvl, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (purging_o !== lvl && n < lim);
  endtask

  task automatic do_reset(input logic floating);
    int t;
    rst_i <= 1'b1;
    probe_host_model_i.set_mode(floating);
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t = 0;
    do
    begin
      @(posedge clk_i);
      t++;
    end
    while (active_o !== 1'b1 && t < 100);
    check("start-up within bound", 32'(t >= 20 && t <= 24), 32'h1);
    check("analog mode", 32'(analog_o), 32'(!floating));
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_digital();
    do_reset(1'b1);
    host_tx <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("receive copy", 32'(mb_rx_o), 32'h0);
    check("driver off", 32'(rs485_oe_n_o), 32'h1);
    mb_de_i <= 1'b1;
    mb_tx_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("tx follows", 32'(rs485_tx_o), 32'h0);
    check("driver on", 32'(rs485_oe_n_o), 32'h0);
    check("no loop current", 32'(loop0_ua_o), 32'h0);
  endtask

  task automatic t_analog_start();
    int n;
    do_reset(1'b0);
    check("start-up purge", 32'(purging_o), 32'h1);
    loops(5000, 3600);
    check("line released in analog", 32'(rs485_oe_n_o), 32'h1);
    // Host trusts readings only once the start-up purge is over
    wait_purging(1'b0, 100, n);
    set_meas(5000, 5000, 5000, 5000);
    check("linear mid scale", 32'(loop0_ua_o), 32'h2ee0);
  endtask

  task automatic t_regs();
    rd_chk("low clip", 8'h08, 32'h0);
    rd_chk("low err", 8'h0c, 32'hc8);
    rd_chk("high clip", 8'h10, 32'h0);
    rd_chk("high err", 8'h14, 32'hc8);
    rd_chk("error level", 8'h18, 32'h0e10);
    rd_chk("zero clip", 8'h1c, 32'h8000_0000);
    rd_chk("status", 8'h04, {24'h0, 1'b0, 1'b1, probe_pkg::ST_RUN, 1'b1});
    rd_chk("unmapped", 8'h20, 32'h0);
    wr(8'h10, 32'h7d1);
    rd_chk("limit above range", 8'h10, 32'h0);
    wr(8'h10, 32'h7d0);
    rd_chk("limit at range top", 8'h10, 32'h7d0);
    // Only byte lane 0 is written; the upper bytes keep the stored limit
    wb_sel_i <= 4'h1;
    wr(8'h10, 32'hffff_ff05);
    wb_sel_i <= 4'hf;
    rd_chk("limit byte lane", 8'h10, 32'h705);
    wr(8'h10, 32'h0);
    loops(5000, 12000);
  endtask

  task automatic t_limits();
    loops(10100, 20000);
    loops(10300, 3600);
    loops(10100, 20000);
    loops(9000, 18400);
    wr(8'h14, 32'h8000_0000);
    loops(10300, 20000);
    loops(-300, 3600);
    loops(-100, 4000);
    wr(8'h1c, 32'h12c);
    loops(200, 4000);
    loops(400, 4640);
  endtask

  task automatic t_select();
    wr(8'h00, 32'he0);
    set_meas(1000, 2000, 5000, 2500);
    check("channel 0 param", 32'(loop0_ua_o), 32'h2ee0);
    check("channel 1 param", 32'(loop1_ua_o), 32'h1f40);
  endtask

  task automatic t_freeze();
    int n;
    int m;
    wr(8'h00, 32'he1);
    wait_purging(1'b1, 10, n);
    check("interval purge starts", 32'(purging_o), 32'h1);
    set_meas(1000, 2000, 7500, 2500);
    check("frozen channel 0", 32'(loop0_ua_o), 32'h2ee0);
    wait_purging(1'b0, 100, m);
    check("purge length", 32'(m + 4 >= 49 && m + 4 <= 53), 32'h1);
    repeat (3) @(posedge clk_i);
    check("released channel 0", 32'(loop0_ua_o), 32'h3e80);
  endtask

  task automatic t_pin();
    int n;
    probe_host_model_i.release_pin(4);
    repeat (10) @(posedge clk_i);
    check("short release ignored", 32'(purging_o), 32'h0);
    probe_host_model_i.release_pin(5);
    wait_purging(1'b1, 10, n);
    check("pin purge starts", 32'(purging_o), 32'h1);
    set_meas(1000, 2000, 5000, 2500);
    check("pin purge frozen", 32'(loop0_ua_o), 32'h3e80);
    wait_purging(1'b0, 100, n);
    check("pin purge ends", 32'(purging_o), 32'h0);
  endtask

  // ==========================================================
  // Main sequence and hang guard
  // ==========================================================
  initial
  begin
    t_digital();
    t_analog_start();
    t_regs();
    t_limits();
    t_select();
    t_freeze();
    t_pin();
    print_verdict();
  end

  // The whole run needs a few hundred cycles; five thousand means a hang
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_errors++;
      print_verdict();
    end
  end
endmodule
`default_nettype wire
